// ==== rtl/pscf_pkg.sv ====
// package for the power status, control and flag register bank
// assumes an 8-bit register port driven by the serial bus front end
package pscf_pkg;
    localparam logic [7:0] ADDR_STATUS  = 8'h05;
    localparam logic [7:0] ADDR_CONTROL = 8'h06;
    localparam logic [7:0] ADDR_FLAGS   = 8'h07;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    // status field positions
    localparam int ST_SEAL    = 7;
    localparam int ST_NVM     = 6;
    localparam int ST_ADAPTER = 5;
    localparam int ST_BUTTON  = 4;
    localparam int ST_SEQ_HI  = 3;
    localparam int ST_SEQ_LO  = 2;
    localparam int ST_CC_HI   = 1;
    localparam int ST_CC_LO   = 0;
    // control field positions
    localparam int CT_MEASURE  = 0;
    localparam int CT_PF_SHUT  = 1;
    localparam logic [7:0] CT_WRITABLE = 8'h02;
    // sequencer state codes
    localparam logic [1:0] SEQ_TRANSIT = 2'h0;
    localparam logic [1:0] SEQ_WAIT_EN = 2'h1;
    localparam logic [1:0] SEQ_ACTIVE  = 2'h2;
    localparam logic [1:0] SEQ_SUSPEND = 2'h3;
    // register state of the bank
    typedef struct packed {
        logic [1:0] adapter_sync;
        logic [1:0] button_sync;
        logic [1:0] pfail_sync;
        logic       powerfail_shutdown_enable;
        logic       coin_cell_measure_start;
        logic [7:0] suspend_rail_flags;
        logic [1:0] prev_seq;
        logic       shutdown_req;
        logic [7:0] rd_data;
    } pscf_state_t;
endpackage : pscf_pkg

// ==== rtl/pscf_regs.sv ====
// status, control and suspend-flag registers of the power manager
// assumes seq_state, rail enables and coin-cell level come from sys_clk
// logic; pins are asynchronous and synchronised here
// What this block does
// - status bit 7 reads 0 while seal fresh, 1 once broken
// - status bit 6 reads 1 once non-volatile settings have changed
// - status bit 5 follows adapter-detect pin level
// - status bit 4 is push-button pin inverted
// - status bits 3-2 give sequencer state code
// - status bits 1-0 give coin-cell level code
// - control bit 0 starts measurement, self-clears; writing 0 ignored
// - control bit 1 set and power-fail low requests full shutdown
// - control bit 1 clear: power-fail never requests shutdown
// - flag bit set when waking from suspend with that rail kept on
// - flag bit 0 after wake from off or rail off; reset 0
`timescale 1ns/1ps
module pscf_regs
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // device condition
    input  wire logic       freshness_seal,
    input  wire logic       nvm_changed,
    input  wire logic [1:0] seq_state,
    input  wire logic [1:0] coin_cell_level,
    input  wire logic       wake_from_suspend,
    input  wire logic [7:0] suspend_rail_enables,
    // pins
    input  wire logic       adapter_detect_pin,
    input  wire logic       push_button_pin,
    input  wire logic       powerfail_out_n,
    // actions
    output logic            coin_cell_measure_start,
    output logic            powerfail_shutdown_enable,
    output logic            shutdown_req
);
    pscf_pkg::pscf_state_t r;
    pscf_pkg::pscf_state_t next_r;
    logic [7:0]            status;
    logic                  power_up;
    logic                  ctrl_wr;

    // sequencer entering active marks a power-up
    assign power_up = r.prev_seq != pscf_pkg::SEQ_ACTIVE
                      && seq_state == pscf_pkg::SEQ_ACTIVE;
    assign ctrl_wr  = reg_wr && reg_addr == pscf_pkg::ADDR_CONTROL;

    always_comb
    begin
        status                      = '0;
        status[pscf_pkg::ST_SEAL]   = freshness_seal;
        status[pscf_pkg::ST_NVM]    = nvm_changed;
        status[pscf_pkg::ST_ADAPTER] = r.adapter_sync[1];
        status[pscf_pkg::ST_BUTTON] = ~r.button_sync[1];
        status[pscf_pkg::ST_SEQ_HI:pscf_pkg::ST_SEQ_LO] = seq_state;
        status[pscf_pkg::ST_CC_HI:pscf_pkg::ST_CC_LO] = coin_cell_level;
    end

    always_comb
    begin
        next_r              = r;
        next_r.adapter_sync = {r.adapter_sync[0], adapter_detect_pin};
        next_r.button_sync  = {r.button_sync[0], push_button_pin};
        next_r.pfail_sync   = {r.pfail_sync[0], powerfail_out_n};
        next_r.prev_seq     = seq_state;
        // measurement start lasts one cycle
        next_r.coin_cell_measure_start = 1'b0;
        if (reg_wr && reg_addr == pscf_pkg::ADDR_CONTROL)
        begin
            next_r.powerfail_shutdown_enable =
                reg_wdata[pscf_pkg::CT_PF_SHUT];
            next_r.coin_cell_measure_start =
                reg_wdata[pscf_pkg::CT_MEASURE];
        end
        next_r.shutdown_req = r.powerfail_shutdown_enable
                            && !r.pfail_sync[1];
        // on power-up, capture rails when waking from suspend, otherwise clear the flags
        if (power_up)
        begin
            if (wake_from_suspend)
                next_r.suspend_rail_flags = suspend_rail_enables;
            else
                next_r.suspend_rail_flags = pscf_pkg::RESET_BYTE;
        end
        case (reg_addr)
            pscf_pkg::ADDR_STATUS:  next_r.rd_data = status;
            pscf_pkg::ADDR_CONTROL: next_r.rd_data =
                {6'h00, r.powerfail_shutdown_enable, 1'b0};
            pscf_pkg::ADDR_FLAGS:   next_r.rd_data = r.suspend_rail_flags;
            default:                next_r.rd_data = pscf_pkg::RESET_BYTE;
        endcase
        if (!reg_rd)
            next_r.rd_data = r.rd_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign reg_rdata                 = r.rd_data;
    assign coin_cell_measure_start   = r.coin_cell_measure_start;
    assign powerfail_shutdown_enable = r.powerfail_shutdown_enable;
    assign shutdown_req              = r.shutdown_req;

    property p_measure_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        (ctrl_wr && reg_wdata[pscf_pkg::CT_MEASURE])
        |=> coin_cell_measure_start
            ##1 (!coin_cell_measure_start || $past(ctrl_wr));
    endproperty
    a_measure_pulse: assert property (p_measure_pulse)
        else $error("measure start not a one-cycle pulse");

    property p_measure_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        (ctrl_wr && !reg_wdata[pscf_pkg::CT_MEASURE])
        |=> !coin_cell_measure_start;
    endproperty
    a_measure_zero: assert property (p_measure_zero)
        else $error("writing zero started a measurement");

    sequence s_pf_low;
        powerfail_shutdown_enable && !powerfail_out_n;
    endsequence
    property p_pf_shut;
        @(posedge sys_clk) disable iff (sys_rst)
        s_pf_low ##1 (powerfail_shutdown_enable && !powerfail_out_n)[*2]
        |=> shutdown_req;
    endproperty
    a_pf_shut: assert property (p_pf_shut)
        else $error("power fail did not request shutdown");

    property p_pf_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(powerfail_shutdown_enable) |-> !shutdown_req;
    endproperty
    a_pf_quiet: assert property (p_pf_quiet)
        else $error("shutdown requested while disabled");

    property p_flag_off;
        @(posedge sys_clk) disable iff (sys_rst)
        ($changed(seq_state) && seq_state == pscf_pkg::SEQ_ACTIVE
         && !wake_from_suspend)
        |=> r.suspend_rail_flags == pscf_pkg::RESET_BYTE;
    endproperty
    a_flag_off: assert property (p_flag_off)
        else $error("flags not cleared on power-up from off");

    property p_flag_susp;
        @(posedge sys_clk) disable iff (sys_rst)
        ($changed(seq_state) && seq_state == pscf_pkg::SEQ_ACTIVE
         && wake_from_suspend)
        |=> r.suspend_rail_flags == $past(suspend_rail_enables);
    endproperty
    a_flag_susp: assert property (p_flag_susp)
        else $error("flags do not match rails kept in suspend");

    property p_ctrl_read;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == pscf_pkg::ADDR_CONTROL)
        |=> reg_rdata[7:2] == 6'h00 && reg_rdata[0] == 1'b0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control reserved bits read nonzero");

    property p_status_read;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == pscf_pkg::ADDR_STATUS)
        |=> reg_rdata[7:6] == $past({freshness_seal, nvm_changed})
            && reg_rdata[3:0] == $past({seq_state, coin_cell_level});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not match live state");

    property p_button;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == pscf_pkg::ADDR_STATUS)
        |=> reg_rdata[4] == !$past(r.button_sync[1])
            && reg_rdata[5] == $past(r.adapter_sync[1]);
    endproperty
    a_button: assert property (p_button)
        else $error("pin level fields wrong");

    // pin back high clears the request after the synchroniser
    sequence s_pf_high;
        powerfail_out_n;
    endsequence
    property p_pf_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        s_pf_high [*3] |=> !shutdown_req;
    endproperty
    a_pf_clear: assert property (p_pf_clear)
        else $error("shutdown held with power fail gone");

    property p_pf_disabled;
        @(posedge sys_clk) disable iff (sys_rst)
        !powerfail_shutdown_enable |=> !shutdown_req;
    endproperty
    a_pf_disabled: assert property (p_pf_disabled)
        else $error("shutdown requested with enable clear");

    property p_ctrl_write;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl_wr |=> powerfail_shutdown_enable
                    == $past(reg_wdata[pscf_pkg::CT_PF_SHUT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("shutdown enable not written");

    property p_ctrl_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        !ctrl_wr |=> $stable(powerfail_shutdown_enable);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep)
        else $error("shutdown enable changed without write");

    property p_measure_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        !ctrl_wr |=> !coin_cell_measure_start;
    endproperty
    a_measure_idle: assert property (p_measure_idle)
        else $error("measurement started without write");

    property p_flag_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        !power_up |=> $stable(r.suspend_rail_flags);
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flags changed outside power-up");

    property p_flag_read;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == pscf_pkg::ADDR_FLAGS)
        |=> reg_rdata == $past(r.suspend_rail_flags);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("flag read does not match flags");

    property p_unmapped;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr != pscf_pkg::ADDR_STATUS
         && reg_addr != pscf_pkg::ADDR_CONTROL
         && reg_addr != pscf_pkg::ADDR_FLAGS)
        |=> reg_rdata == pscf_pkg::RESET_BYTE;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_rd_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");

    property p_ctrl_rd_en;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == pscf_pkg::ADDR_CONTROL)
        |=> reg_rdata[pscf_pkg::CT_PF_SHUT]
            == $past(powerfail_shutdown_enable);
    endproperty
    a_ctrl_rd_en: assert property (p_ctrl_rd_en)
        else $error("shutdown enable read back wrong");

    property p_reset_out;
        @(posedge sys_clk)
        $past(sys_rst) |-> r.suspend_rail_flags == pscf_pkg::RESET_BYTE
            && !shutdown_req && !coin_cell_measure_start;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("state not cleared by reset");

    // settled pin levels reach the status read
    sequence s_btn_high;
        push_button_pin;
    endsequence
    property p_button_live;
        @(posedge sys_clk) disable iff (sys_rst)
        (s_btn_high [*3] ##0 (reg_rd && reg_addr == pscf_pkg::ADDR_STATUS))
        |=> !reg_rdata[pscf_pkg::ST_BUTTON];
    endproperty
    a_button_live: assert property (p_button_live)
        else $error("released button reads pressed");

    sequence s_adp_high;
        adapter_detect_pin;
    endsequence
    property p_adapter_live;
        @(posedge sys_clk) disable iff (sys_rst)
        (s_adp_high [*3] ##0 (reg_rd && reg_addr == pscf_pkg::ADDR_STATUS))
        |=> reg_rdata[pscf_pkg::ST_ADAPTER];
    endproperty
    a_adapter_live: assert property (p_adapter_live)
        else $error("adapter high reads inactive");
endmodule : pscf_regs

// ==== verif/power_status_control_flags_bench.sv ====
// self-checking bench for the power status, control and flag registers
// assumes the host model drives the register port
`timescale 1ns/1ps
module power_status_control_flags_bench;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       seal = 1'b0;
    logic       nvm = 1'b0;
    logic [1:0] seq = 2'h0;
    logic [1:0] cc = 2'h0;
    logic       wake = 1'b0;
    logic [7:0] rails = 8'h00;
    logic       adp = 1'b0;
    logic       btn = 1'b1;
    logic       pfo = 1'b1;
    logic       meas;
    logic       pfen;
    logic       shut;
    logic       rd_d = 1'b0;
    logic [7:0] r;
    logic [7:0] exp_q[$];
    int         n_fail = 0;
    int         total_checks = 0;

    always #5 sys_clk = ~sys_clk;

    pscf_host u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    pscf_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .freshness_seal(seal), .nvm_changed(nvm), .seq_state(seq),
        .coin_cell_level(cc), .wake_from_suspend(wake),
        .suspend_rail_enables(rails), .adapter_detect_pin(adp),
        .push_button_pin(btn), .powerfail_out_n(pfo),
        .coin_cell_measure_start(meas),
        .powerfail_shutdown_enable(pfen), .shutdown_req(shut));

    task automatic check_val(input logic [7:0] got, input logic [7:0] e);
        total_checks++;
        if (got !== e)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : check_val

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask : rd_exp

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // read data compared on the falling edge half a cycle after the edge that registers the read
    always @(posedge sys_clk) rd_d <= reg_rd;
    always @(negedge sys_clk)
        if (rd_d)
            check_val(reg_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);

    initial
    begin
        #100000;
        n_fail++;
        end_sim();
    end

    initial
    begin
        void'($urandom(32'h58975141));
        repeat (5) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        rd_exp(pscf_pkg::ADDR_CONTROL, 8'h00);
        rd_exp(pscf_pkg::ADDR_FLAGS, 8'h00);
        u_host.xfer(1'b1, pscf_pkg::ADDR_CONTROL, 8'hfd);
        @(negedge sys_clk);
        check_val({7'h00, meas}, 8'h01);
        @(negedge sys_clk);
        check_val({7'h00, meas}, 8'h00);
        rd_exp(pscf_pkg::ADDR_CONTROL, 8'h00);
        u_host.xfer(1'b1, pscf_pkg::ADDR_CONTROL, 8'hfe);
        @(negedge sys_clk);
        check_val({6'h00, pfen, meas}, 8'h02);
        u_host.xfer(1'b1, pscf_pkg::ADDR_FLAGS, 8'hff);
        rd_exp(pscf_pkg::ADDR_FLAGS, 8'h00);
        rd_exp(8'h20, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            r = 8'($urandom);
            {seal, nvm, adp, btn, seq, cc} = r;
            repeat (3) @(posedge sys_clk);
            #1;
            rd_exp(pscf_pkg::ADDR_STATUS, r ^ 8'h10);
        end
        u_host.xfer(1'b1, pscf_pkg::ADDR_STATUS, 8'hff);
        rd_exp(pscf_pkg::ADDR_STATUS, r ^ 8'h10);
        pfo = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check_val({7'h00, shut}, 8'h01);
        u_host.xfer(1'b1, pscf_pkg::ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        check_val({6'h00, pfen, shut}, 8'h00);
        pfo = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            r = 8'($urandom);
            seq = pscf_pkg::SEQ_SUSPEND;
            wake = (k == 0);
            rails = r;
            repeat (2) @(posedge sys_clk);
            #1;
            seq = pscf_pkg::SEQ_ACTIVE;
            repeat (2) @(posedge sys_clk);
            #1;
            rails = ~r;
            rd_exp(pscf_pkg::ADDR_FLAGS, (k == 0) ? r : 8'h00);
        end
        repeat (2) @(posedge sys_clk);
        end_sim();
    end
endmodule : power_status_control_flags_bench

// ==== verif/pscf_host.sv ====
// host model driving the register port of the bank
// assumes one caller process and a free-running sys_clk
`timescale 1ns/1ps
module pscf_host
(
    // clock
    input  wire logic       sys_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // one-cycle strobe; data inverted once released so nothing lingers
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = ~d;
    endtask : xfer
endmodule : pscf_host
